/* hdl/rsc_device.sv */
// Implementation choice: the device side of the link; the AHB-Lite slave port is in rsc_host.
`timescale 1ns/1ps
module rsc_device (
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    rsc_link_if.dev LINK,
    input wire logic CLOCKLESS_I,
    input wire logic ASSESS_DONE_FLAG_I,
    input wire logic CCA_IDLE_I,
    input wire logic RX_START_I,
    input wire logic FRAME_END_I,
    input wire logic ACK_PENDING_I,
    input wire logic ACK_READY_I,
    input wire logic CSMA_FAIL_I,
    input wire logic NO_ACK_I,
    output logic [4:0] STATE_O,
    output logic TX_BEGIN_O,
    output logic ACK_SEND_O,
    output logic [7:0] RETRY_CTRL_O
);
    rsc_pkg::rsc_state_t state_r;
    rsc_pkg::rsc_state_t state_nxt;
    rsc_pkg::rsc_state_t tgt_r;
    rsc_pkg::rsc_state_t tgt_nxt;
    rsc_pkg::rsc_state_t go_tgt;
    logic go_en;
    logic [2:0] res_r;
    logic [2:0] res_nxt;
    logic [4:0] cmd_r;
    logic [4:0] field_r;
    logic [4:0] field_nxt;
    logic done_flag_r;
    logic idle_flag_r;
    logic trig_q_r;
    logic trig_rise;
    logic trig_fall;
    logic asleep;
    logic wr_en;
    logic rd_en;
    logic wr_cmd;
    logic [4:0] cmd_w;
    logic tr_load;
    logic tr_done;
    logic sym_load;
    logic sym_done;
    logic ack_send;
    logic busy_state;
    logic syn_ok;
    logic [7:0] rdata_r;
    logic [7:0] rd_mux;
    logic ack_r;
    logic nak_r;
    logic tx_begin_r;
    logic ack_send_r;
    logic [7:0] cfg_r [rsc_pkg::CFG_N];

    assign asleep = (state_r == rsc_pkg::ST_SLEEP);
    assign wr_en = LINK.req && LINK.we && !asleep;
    assign rd_en = LINK.req && !LINK.we && !asleep;
    assign wr_cmd = wr_en && (LINK.addr == rsc_pkg::A_CMD);
    assign cmd_w = LINK.wdata[4:0];
    assign trig_rise = LINK.trig && !trig_q_r;
    assign trig_fall = !LINK.trig && trig_q_r;
    assign busy_state = (state_r == rsc_pkg::ST_RX)
        || (state_r == rsc_pkg::ST_TX)
        || (state_r == rsc_pkg::ST_AACK_RX)
        || (state_r == rsc_pkg::ST_ARET_TX)
        || (state_r == rsc_pkg::ST_PENDING);

    // Unclocked states and a pending transition toward sleep reject forced synth
    assign syn_ok = (state_r != rsc_pkg::ST_PON)
        && !asleep
        && !(field_r[4:2] == 3'h7 && field_r != rsc_pkg::ST_PENDING)
        && !(state_r == rsc_pkg::ST_PENDING
             && tgt_r == rsc_pkg::ST_SLEEP);

    rsc_timer u_trans (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RESET_N_I),
        .load_i(tr_load),
        .count_i(rsc_pkg::TRANSITION_CYC),
        .busy_o(),
        .done_o(tr_done)
    );

    rsc_timer u_symbol (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RESET_N_I),
        .load_i(sym_load),
        .count_i(rsc_pkg::SYMBOL_CYC),
        .busy_o(),
        .done_o(sym_done)
    );

    // Later assignments take priority: commands override radio events
    always_comb begin
        state_nxt = state_r;
        tgt_nxt = tgt_r;
        res_nxt = res_r;
        go_en = 1'b0;
        go_tgt = rsc_pkg::ST_OFF;
        sym_load = 1'b0;
        ack_send = 1'b0;
        if (state_r == rsc_pkg::ST_PENDING && tr_done) begin
            state_nxt = tgt_r;
        end
        case (state_r)
            rsc_pkg::ST_RX_ON: begin
                if (RX_START_I) state_nxt = rsc_pkg::ST_RX;
            end
            rsc_pkg::ST_RX: begin
                if (FRAME_END_I) state_nxt = rsc_pkg::ST_RX_ON;
            end
            rsc_pkg::ST_TX: begin
                if (FRAME_END_I) state_nxt = rsc_pkg::ST_SYNTH;
            end
            rsc_pkg::ST_AACK_ON: begin
                if (RX_START_I) begin
                    state_nxt = rsc_pkg::ST_AACK_RX;
                    res_nxt = rsc_pkg::RES_INVALID;
                end
            end
            rsc_pkg::ST_AACK_RX: begin
                if (ACK_READY_I && cfg_r[rsc_pkg::CFG_RETRY_IDX]
                        [rsc_pkg::SLOTTED_BIT]) begin
                    res_nxt = rsc_pkg::RES_WAIT_ACK;
                end
                if (trig_rise && res_r == rsc_pkg::RES_WAIT_ACK) begin
                    ack_send = 1'b1;
                end
                if (FRAME_END_I) begin
                    state_nxt = rsc_pkg::ST_AACK_ON;
                    res_nxt = rsc_pkg::RES_OK;
                end
            end
            rsc_pkg::ST_ARET_TX: begin
                if (FRAME_END_I) begin
                    state_nxt = rsc_pkg::ST_ARET_RDY;
                    res_nxt = ACK_PENDING_I ? rsc_pkg::RES_OK_MORE
                        : rsc_pkg::RES_OK;
                end else if (CSMA_FAIL_I) begin
                    state_nxt = rsc_pkg::ST_ARET_RDY;
                    res_nxt = rsc_pkg::RES_BUSY_FAIL;
                end else if (NO_ACK_I) begin
                    state_nxt = rsc_pkg::ST_ARET_RDY;
                    res_nxt = rsc_pkg::RES_NO_ACK;
                end
            end
            rsc_pkg::ST_OFF: begin
                if (trig_rise) begin
                    go_en = 1'b1;
                    go_tgt = rsc_pkg::ST_SLEEP;
                end
            end
            rsc_pkg::ST_SLEEP: begin
                if (trig_fall) begin
                    go_en = 1'b1;
                    go_tgt = rsc_pkg::ST_OFF;
                end
            end
            rsc_pkg::ST_SYNTH: begin
                if (trig_rise) begin
                    state_nxt = rsc_pkg::ST_TX;
                    sym_load = 1'b1;
                end
            end
            rsc_pkg::ST_ARET_RDY: begin
                if (trig_rise) begin
                    state_nxt = rsc_pkg::ST_ARET_TX;
                    res_nxt = rsc_pkg::RES_INVALID;
                    sym_load = 1'b1;
                end
            end
            default: begin
            end
        endcase
        if (wr_cmd) begin
            case (cmd_w)
                rsc_pkg::CMD_TX_START: begin
                    if (state_r == rsc_pkg::ST_SYNTH) begin
                        state_nxt = rsc_pkg::ST_TX;
                        sym_load = 1'b1;
                    end else if (state_r == rsc_pkg::ST_ARET_RDY) begin
                        state_nxt = rsc_pkg::ST_ARET_TX;
                        res_nxt = rsc_pkg::RES_INVALID;
                        sym_load = 1'b1;
                    end
                end
                rsc_pkg::CMD_FORCE_OFF: begin
                    if (state_r != rsc_pkg::ST_PON) begin
                        go_en = 1'b1;
                        go_tgt = rsc_pkg::ST_OFF;
                    end
                end
                rsc_pkg::CMD_FORCE_SYN: begin
                    if (syn_ok) begin
                        go_en = 1'b1;
                        go_tgt = rsc_pkg::ST_SYNTH;
                    end
                end
                rsc_pkg::CMD_RX_ON, rsc_pkg::CMD_OFF, rsc_pkg::CMD_SYNTH,
                rsc_pkg::CMD_AACK_ON, rsc_pkg::CMD_ARET_ON: begin
                    if (!busy_state) begin
                        go_en = 1'b1;
                        go_tgt = rsc_pkg::rsc_state_t'(cmd_w);
                    end
                end
                default: begin
                end
            endcase
        end
        if (go_en) begin
            state_nxt = rsc_pkg::ST_PENDING;
            tgt_nxt = go_tgt;
        end
    end

    assign tr_load = go_en;

    // Unclocked variants of the listen states and of the auto-ack receive state
    always_comb begin
        case (state_nxt)
            rsc_pkg::ST_RX_ON: field_nxt = CLOCKLESS_I
                ? rsc_pkg::F_LISTEN_CLOCKLESS : state_nxt;
            rsc_pkg::ST_AACK_ON: field_nxt = CLOCKLESS_I
                ? rsc_pkg::F_AACK_ON_NOCLK : state_nxt;
            rsc_pkg::ST_AACK_RX: field_nxt = CLOCKLESS_I
                ? rsc_pkg::F_AACK_RX_NOCLK : state_nxt;
            default: field_nxt = state_nxt;
        endcase
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            state_r <= rsc_pkg::ST_PON;
            tgt_r <= rsc_pkg::ST_PON;
            field_r <= rsc_pkg::ST_PON;
        end else begin
            state_r <= state_nxt;
            tgt_r <= tgt_nxt;
            field_r <= field_nxt;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            res_r <= rsc_pkg::RES_OK;
        end else begin
            res_r <= res_nxt;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            cmd_r <= rsc_pkg::CMD_RESET;
        end else if (wr_cmd) begin
            cmd_r <= cmd_w;
        end
    end

    // Done flag clears on a status read; a new completion wins
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            done_flag_r <= 1'b0;
            idle_flag_r <= 1'b0;
        end else if (ASSESS_DONE_FLAG_I) begin
            done_flag_r <= 1'b1;
            idle_flag_r <= CCA_IDLE_I;
        end else if (rd_en && LINK.addr == rsc_pkg::A_STATUS) begin
            done_flag_r <= 1'b0;
        end
    end

    for (genvar g = 0; g < rsc_pkg::CFG_N; g++) begin : g_cfg
        always_ff @(posedge CORE_CLK_I) begin
            if (!RESET_N_I) begin
                cfg_r[g] <= rsc_pkg::CFG_RESET[g];
            end else if (wr_en && LINK.addr == rsc_pkg::CFG_ADDR[g]) begin
                cfg_r[g] <= LINK.wdata;
            end
        end
    end

    always_comb begin
        rd_mux = 8'h00;
        if (LINK.addr == rsc_pkg::A_STATUS) begin
            rd_mux = {done_flag_r, idle_flag_r, 1'b0, field_r};
        end else if (LINK.addr == rsc_pkg::A_CMD) begin
            rd_mux = {res_r, cmd_r};
        end
        for (int i = 0; i < rsc_pkg::CFG_N; i++) begin
            if (LINK.addr == rsc_pkg::CFG_ADDR[i]) rd_mux = cfg_r[i];
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            rdata_r <= 8'h00;
            ack_r <= 1'b0;
            nak_r <= 1'b0;
        end else begin
            rdata_r <= rd_en ? rd_mux : 8'h00;
            ack_r <= LINK.req;
            nak_r <= LINK.req && asleep;
        end
    end

    // A forced off during the symbol wait cancels the frame start
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            tx_begin_r <= 1'b0;
            ack_send_r <= 1'b0;
        end else begin
            tx_begin_r <= sym_done && (state_r == rsc_pkg::ST_TX
                || state_r == rsc_pkg::ST_ARET_TX);
            ack_send_r <= ack_send;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            trig_q_r <= 1'b0;
        end else begin
            trig_q_r <= LINK.trig;
        end
    end

    assign LINK.rdata = rdata_r;
    assign LINK.ack = ack_r;
    assign LINK.nak = nak_r;
    assign STATE_O = field_r;
    assign TX_BEGIN_O = tx_begin_r;
    assign ACK_SEND_O = ack_send_r;
    assign RETRY_CTRL_O = cfg_r[rsc_pkg::CFG_RETRY_IDX];
endmodule // rsc_device

/* hdl/rsc_pkg.sv */
package rsc_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int SYMBOL_NS = 16000;
    localparam int TRANSITION_NS = 1000;
    localparam int TMR_W = 12;
    localparam logic [TMR_W-1:0] SYMBOL_CYC =
        TMR_W'((SYMBOL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] TRANSITION_CYC =
        TMR_W'((TRANSITION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Device register offsets on the link
    localparam int ADDR_W = 6;
    localparam logic [5:0] A_STATUS = 6'h01;
    localparam logic [5:0] A_CMD = 6'h02;
    localparam int CFG_N = 8;
    localparam logic [5:0] CFG_ADDR [CFG_N] = '{
        6'h04, 6'h08, 6'h09, 6'h17, 6'h2c, 6'h2d, 6'h2e, 6'h2f};
    localparam logic [7:0] CFG_RESET [CFG_N] = '{
        8'h20, 8'h00, 8'h00, 8'h00, 8'h30, 8'h00, 8'h00, 8'h00};
    localparam int CFG_RETRY_IDX = 4;
    localparam int SLOTTED_BIT = 0;

    // Field positions and reset values
    localparam int DONE_BIT = 7;
    localparam int IDLE_BIT = 6;
    localparam int RES_LSB = 5;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [4:0] CMD_RESET = 5'h00;

    typedef enum logic [4:0] {
        ST_PON = 5'h00,
        ST_RX = 5'h01,
        ST_TX = 5'h02,
        ST_RX_ON = 5'h06,
        ST_OFF = 5'h08,
        ST_SYNTH = 5'h09,
        ST_SLEEP = 5'h0f,
        ST_AACK_RX = 5'h11,
        ST_ARET_TX = 5'h12,
        ST_AACK_ON = 5'h16,
        ST_ARET_RDY = 5'h19,
        ST_PENDING = 5'h1f
    } rsc_state_t;

    localparam logic [4:0] F_LISTEN_CLOCKLESS = 5'h1c;
    localparam logic [4:0] F_AACK_ON_NOCLK = 5'h1d;
    localparam logic [4:0] F_AACK_RX_NOCLK = 5'h1e;

    // State command codes
    localparam logic [4:0] CMD_NOP = 5'h00;
    localparam logic [4:0] CMD_TX_START = 5'h02;
    localparam logic [4:0] CMD_FORCE_OFF = 5'h03;
    localparam logic [4:0] CMD_FORCE_SYN = 5'h04;
    localparam logic [4:0] CMD_RX_ON = 5'h06;
    localparam logic [4:0] CMD_OFF = 5'h08;
    localparam logic [4:0] CMD_SYNTH = 5'h09;
    localparam logic [4:0] CMD_AACK_ON = 5'h16;
    localparam logic [4:0] CMD_ARET_ON = 5'h19;

    // Transaction result codes
    localparam logic [2:0] RES_OK = 3'h0;
    localparam logic [2:0] RES_OK_MORE = 3'h1;
    localparam logic [2:0] RES_WAIT_ACK = 3'h2;
    localparam logic [2:0] RES_BUSY_FAIL = 3'h3;
    localparam logic [2:0] RES_NO_ACK = 3'h5;
    localparam logic [2:0] RES_INVALID = 3'h7;

    // Controller registers on AHB-Lite
    localparam logic [7:0] H_ACCESS = 8'h00;
    localparam logic [7:0] H_RESULT = 8'h04;
    localparam logic [7:0] H_STATE = 8'h08;
    localparam logic [7:0] H_TRIG = 8'h0c;
    localparam int HA_WE_BIT = 16;
    localparam int HA_ADDR_LSB = 8;
    localparam int HR_BUSY_BIT = 8;
    localparam int HR_NAK_BIT = 9;
    localparam int HR_REFUSED_BIT = 10;

endpackage

/* hdl/rsc_link_if.sv */
`timescale 1ns/1ps
interface rsc_link_if;
    logic req;
    logic we;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack;
    logic nak;
    logic trig;

    modport dev (
        input req, we, addr, wdata, trig,
        output rdata, ack, nak
    );
    modport host (
        output req, we, addr, wdata, trig,
        input rdata, ack, nak
    );
endinterface

/* hdl/rsc_timer.sv */
`timescale 1ns/1ps
module rsc_timer (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [rsc_pkg::TMR_W-1:0] count_i,
    output logic busy_o,
    output logic done_o
);
    logic [rsc_pkg::TMR_W-1:0] cnt_r;
    logic done_r;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_r <= '0;
        end else if (load_i) begin
            cnt_r <= count_i;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // Pulse on the edge where the count runs out
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            done_r <= 1'b0;
        end else begin
            done_r <= !load_i && (cnt_r == rsc_pkg::TMR_W'(1));
        end
    end

    assign busy_o = (cnt_r != '0);
    assign done_o = done_r;
endmodule // rsc_timer

/* hdl/rsc_host.sv */
`timescale 1ns/1ps
module rsc_host (
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    rsc_link_if.host LINK,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O
);
    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_WAIT = 2'b01
    } rsc_hstate_t;

    rsc_hstate_t hst_r;
    logic ap_valid_r;
    logic ap_write_r;
    logic [7:0] ap_addr_r;
    logic [31:0] hrdata_r;
    logic req_r;
    logic we_r;
    logic [5:0] addr_r;
    logic [7:0] wdata_r;
    logic follow_r;
    logic [7:0] rdata_r;
    logic nak_r;
    logic refused_r;
    logic [4:0] mirror_r;
    logic trig_r;
    logic acc_wr;
    logic is_cmd;
    logic bad_cmd;
    logic start;
    logic refuse;

    assign acc_wr = ap_valid_r && ap_write_r && ap_addr_r == rsc_pkg::H_ACCESS;
    assign is_cmd = HWDATA_I[rsc_pkg::HA_WE_BIT]
        && HWDATA_I[13:8] == rsc_pkg::A_CMD;
    // Checks use the last state read back from the device
    assign bad_cmd = is_cmd && (mirror_r == rsc_pkg::ST_PENDING
        || (HWDATA_I[4:0] == rsc_pkg::CMD_FORCE_SYN
            && (mirror_r == rsc_pkg::ST_PON
                || mirror_r == rsc_pkg::ST_SLEEP
                || mirror_r[4:2] == 3'h7)));
    assign refuse = acc_wr && (hst_r != HS_IDLE || bad_cmd);
    assign start = acc_wr && !refuse;

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            ap_valid_r <= 1'b0;
            ap_write_r <= 1'b0;
            ap_addr_r <= 8'h00;
        end else begin
            ap_valid_r <= HSEL_I && HTRANS_I[1] && HREADY_I;
            ap_write_r <= HWRITE_I;
            ap_addr_r <= HADDR_I[7:0];
        end
    end

    // Read data is captured in the address phase, so no wait states
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            hrdata_r <= 32'h0000_0000;
        end else if (HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I) begin
            case (HADDR_I[7:0])
                rsc_pkg::H_ACCESS: hrdata_r <= {15'h0, we_r,
                    2'h0, addr_r, wdata_r};
                rsc_pkg::H_RESULT: hrdata_r <= {21'h0, refused_r,
                    nak_r, hst_r != HS_IDLE, rdata_r};
                rsc_pkg::H_STATE: hrdata_r <= {27'h0, mirror_r};
                rsc_pkg::H_TRIG: hrdata_r <= {31'h0, trig_r};
                default: hrdata_r <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            hst_r <= HS_IDLE;
            req_r <= 1'b0;
            we_r <= 1'b0;
            addr_r <= 6'h00;
            wdata_r <= 8'h00;
            follow_r <= 1'b0;
        end else begin
            req_r <= 1'b0;
            case (hst_r)
                HS_IDLE: begin
                    if (start) begin
                        req_r <= 1'b1;
                        we_r <= HWDATA_I[rsc_pkg::HA_WE_BIT];
                        addr_r <= HWDATA_I[13:8];
                        wdata_r <= HWDATA_I[7:0];
                        follow_r <= is_cmd;
                        hst_r <= HS_WAIT;
                    end
                end
                HS_WAIT: begin
                    if (LINK.ack && follow_r) begin
                        req_r <= 1'b1;
                        we_r <= 1'b0;
                        addr_r <= rsc_pkg::A_STATUS;
                        follow_r <= 1'b0;
                    end else if (LINK.ack) begin
                        hst_r <= HS_IDLE;
                    end
                end
                default: hst_r <= HS_IDLE;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            rdata_r <= 8'h00;
            nak_r <= 1'b0;
            mirror_r <= rsc_pkg::ST_PON;
        end else if (hst_r == HS_WAIT && LINK.ack) begin
            rdata_r <= LINK.rdata;
            nak_r <= LINK.nak;
            if (!we_r && addr_r == rsc_pkg::A_STATUS && !LINK.nak) begin
                mirror_r <= LINK.rdata[4:0];
            end
        end
    end

    // Refusal is sticky; a new refusal wins over the clearing write
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            refused_r <= 1'b0;
        end else if (refuse) begin
            refused_r <= 1'b1;
        end else if (ap_valid_r && ap_write_r
                && ap_addr_r == rsc_pkg::H_RESULT
                && HWDATA_I[rsc_pkg::HR_REFUSED_BIT]) begin
            refused_r <= 1'b0;
        end
    end

    // Software pulses the trigger at the slot boundary for a slotted ack
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            trig_r <= 1'b0;
        end else if (ap_valid_r && ap_write_r
                && ap_addr_r == rsc_pkg::H_TRIG) begin
            trig_r <= HWDATA_I[0];
        end
    end

    assign LINK.req = req_r;
    assign LINK.we = we_r;
    assign LINK.addr = addr_r;
    assign LINK.wdata = wdata_r;
    assign LINK.trig = trig_r;
    assign HRDATA_O = hrdata_r;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;
endmodule // rsc_host

/* tb/rsc_link_checker.sv */
`timescale 1ns/1ps
module rsc_link_checker (
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    input wire logic req,
    input wire logic we,
    input wire logic [5:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic ack,
    input wire logic nak,
    input wire logic trig
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    wire logic rd_st = ack && !we && !nak && addr == 6'h01;
    wire logic rd_cmd = ack && !we && !nak && addr == 6'h02;
    a_ack_one_cycle: assert property (req |=> ack && !req)
        else $error("link answer missing one cycle after request");
    a_ack_has_cause: assert property (ack |-> $past(req))
        else $error("link answer without request");
    a_nak_blank: assert property (nak |-> ack && rdata == 8'h00)
        else $error("refused access returned data");
    a_state_legal: assert property (rd_st |-> rdata[4:0] inside
        {5'h00, 5'h01, 5'h02, 5'h06, 5'h08, 5'h09, 5'h0f, 5'h11, 5'h12,
        5'h16, 5'h19, 5'h1c, 5'h1d, 5'h1e, 5'h1f})
        else $error("state field shows a reserved code");
    a_rsvd_bit_zero: assert property (rd_st |-> !rdata[5])
        else $error("reserved status bit set");
    a_result_legal: assert property (rd_cmd |->
        !(rdata[7:5] inside {3'h4, 3'h6}))
        else $error("transaction result shows a reserved code");
    a_write_held: assert property (req && we |=> $stable({we, addr, wdata}))
        else $error("write qualifiers moved after request");
    a_status_after_cmd: assert property (req && we && addr == 6'h02
        |-> ##2 req && !we && addr == 6'h01)
        else $error("no status read after state command");
    c_nak: cover property (nak);
    c_pending: cover property (rd_st && rdata[4:0] == 5'h1f);
    c_trig: cover property ($rose(trig));
endmodule // rsc_link_checker

/* tb/test_radio_state_command_status_regs.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
    error_cnt++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module test_radio_state_command_status_regs;
    logic clk = 0, rst_n = 0, hsel = 0, hwr = 0, hrdy, hresp, txb;
    logic asd, ncl = 1'b0;
    logic [1:0] htr = 0;
    logic [5:0] ev = 6'h00;
    logic [4:0] st;
    logic [7:0] rc;
    logic [31:0] ha = 0, hwd = 0, hrd, r;
    logic [4:0] cs [9] = '{5'h08, 5'h09, 5'h00, 5'h05, 5'h06, 5'h04,
        5'h16, 5'h03, 5'h19};
    logic [4:0] es [9] = '{5'h08, 5'h09, 5'h09, 5'h09, 5'h06, 5'h09,
        5'h16, 5'h08, 5'h19};
    logic [2:0] rs [3] = '{3'h1, 3'h3, 3'h5};
    int error_cnt = 0, total_checks = 0, k, na = 0;
    always #2.5 clk = ~clk;
    // Counts slotted acknowledgement launches, a one-cycle pulse
    always @(posedge clk) if (asd === 1'b1) na <= na + 1;
    rsc_link_if lk ();
    rsc_device i_rsc_device (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
        .LINK(lk), .CLOCKLESS_I(ncl), .ASSESS_DONE_FLAG_I(ev[3]), .CCA_IDLE_I(ev[3]),
        .RX_START_I(ev[4]), .FRAME_END_I(ev[0]), .ACK_PENDING_I(ev[0]),
        .ACK_READY_I(ev[5]), .CSMA_FAIL_I(ev[1]), .NO_ACK_I(ev[2]),
        .STATE_O(st), .TX_BEGIN_O(txb), .ACK_SEND_O(asd), .RETRY_CTRL_O(rc));
    rsc_host i_rsc_host (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .LINK(lk),
        .HSEL_I(hsel), .HADDR_I(ha), .HTRANS_I(htr), .HWRITE_I(hwr),
        .HSIZE_I(3'h2), .HWDATA_I(hwd), .HREADY_I(hrdy), .HRDATA_O(hrd),
        .HREADYOUT_O(hrdy), .HRESP_O(hresp));
    rsc_link_checker i_rsc_link_checker (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
        .req(lk.req), .we(lk.we), .addr(lk.addr), .wdata(lk.wdata),
        .rdata(lk.rdata), .ack(lk.ack), .nak(lk.nak), .trig(lk.trig));
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", error_cnt, total_checks);
        if (error_cnt == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic lim(input int n);
        if (n >= 50) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask
    task automatic hs;
        int n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hrdy !== 1'b1 && n < 50);
        lim(n);
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge clk);
        ha <= {24'h0, a};
        hwr <= w;
        htr <= 2'h2;
        hsel <= 1'b1;
        hs();
        htr <= 2'h0;
        hwd <= d;
        hs();
        r = hrd;
    endtask
    // Device access goes through the host's mailbox; poll until not busy
    task automatic dv(input logic w, input logic [5:0] a,
            input logic [7:0] d);
        int n = 0;
        ahb(1'b1, rsc_pkg::H_ACCESS, {15'h0, w, 2'h0, a, d});
        do begin
            ahb(1'b0, rsc_pkg::H_RESULT, 32'h0);
            n++;
        end while (r[8] !== 1'b0 && n < 50);
        lim(n);
    endtask
    task automatic pulse(input logic [5:0] v);
        ev <= v;
        @(posedge clk);
        ev <= 6'h00;
    endtask
    task automatic cmd(input logic [4:0] c, input logic [4:0] e);
        logic [4:0] p;
        p = st;
        dv(1'b1, rsc_pkg::A_CMD, {3'h0, c});
        ahb(1'b0, rsc_pkg::H_STATE, 32'h0);
        `CHK(r[4:0], (e != p) ? 5'h1f : p)
        repeat (210) @(posedge clk);
        dv(1'b0, rsc_pkg::A_STATUS, 8'h0);
        `CHK(r[4:0], e)
        `CHK(st, e)
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        dv(1'b0, rsc_pkg::A_CMD, 8'h0);
        `CHK(r[7:0], 8'h00)
        `CHK(rc, rsc_pkg::CFG_RESET[rsc_pkg::CFG_RETRY_IDX])
        ahb(1'b0, 8'h10, 32'h0);
        `CHK(r, 32'h0)
        `CHK(hresp, 1'b0)
        pulse(6'h08);
        dv(1'b0, rsc_pkg::A_STATUS, 8'h0);
        `CHK(r[7:0], 8'hc0)
        dv(1'b0, rsc_pkg::A_STATUS, 8'h0);
        `CHK(r[7:0], 8'h40)
        for (int i = 0; i < 9; i++)
            cmd(cs[i], es[i]);
        for (int i = 0; i < 3; i++) begin
            ahb(1'b1, rsc_pkg::H_TRIG, 32'h1);
            repeat (5) @(posedge clk);
            dv(1'b0, rsc_pkg::A_CMD, 8'h0);
            `CHK(r[7:5], rsc_pkg::RES_INVALID)
            `CHK(st, rsc_pkg::ST_ARET_TX)
            pulse(6'h01 << i);
            dv(1'b0, rsc_pkg::A_CMD, 8'h0);
            `CHK(r[7:5], rs[i])
            ahb(1'b1, rsc_pkg::H_TRIG, 32'h0);
            repeat (210) @(posedge clk);
        end
        cmd(rsc_pkg::CMD_SYNTH, rsc_pkg::ST_SYNTH);
        dv(1'b1, rsc_pkg::A_CMD, {3'h0, rsc_pkg::CMD_TX_START});
        k = 0;
        while (txb !== 1'b1 && k < 4000) begin
            @(negedge clk);
            k++;
        end
        `CHK(k > rsc_pkg::SYMBOL_CYC - 60
            && k < rsc_pkg::SYMBOL_CYC + 2, 1'b1)
        cmd(rsc_pkg::CMD_FORCE_OFF, rsc_pkg::ST_OFF);
        ahb(1'b1, rsc_pkg::H_TRIG, 32'h1);
        repeat (210) @(posedge clk);
        dv(1'b0, rsc_pkg::A_STATUS, 8'h0);
        `CHK(r[9], 1'b1)
        `CHK(st, rsc_pkg::ST_SLEEP)
        ahb(1'b1, rsc_pkg::H_TRIG, 32'h0);
        repeat (210) @(posedge clk);
        dv(1'b0, rsc_pkg::A_STATUS, 8'h0);
        `CHK(r[9:0], 10'h048)
        dv(1'b1, rsc_pkg::A_CMD, {3'h0, rsc_pkg::CMD_AACK_ON});
        // Host still mirrors the pending state, so this one is refused
        dv(1'b1, rsc_pkg::A_CMD, {3'h0, rsc_pkg::CMD_SYNTH});
        `CHK(r[10], 1'b1)
        dv(1'b1, 6'h2c, 8'h31);
        `CHK(rc, 8'h31)
        repeat (210) @(posedge clk);
        dv(1'b0, rsc_pkg::A_STATUS, 8'h0);
        `CHK(r[4:0], rsc_pkg::ST_AACK_ON)
        pulse(6'h10);
        @(posedge clk);
        pulse(6'h20);
        dv(1'b0, rsc_pkg::A_CMD, 8'h0);
        `CHK(r[7:5], rsc_pkg::RES_WAIT_ACK)
        `CHK(st, rsc_pkg::ST_AACK_RX)
        ahb(1'b1, rsc_pkg::H_TRIG, 32'h1);
        repeat (3) @(posedge clk);
        `CHK(na, 1)
        ncl <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(st, rsc_pkg::F_AACK_RX_NOCLK)
        pulse(6'h01);
        @(posedge clk);
        `CHK(st, rsc_pkg::F_AACK_ON_NOCLK)
        tally_and_finish();
    end
endmodule // test_radio_state_command_status_regs
